// *** logic/ssam_defs.svh ***
// Offsets, bit positions, codes and reset values of the servo status and alarm monitor
`ifndef SSAM_DEFS_SVH
`define SSAM_DEFS_SVH
// ==========================================================
// Register byte offsets; the history base is the value of haddr[7:6]
`define SSAM_OFS_STAT_ONE 8'h00
`define SSAM_OFS_STAT_TWO 8'h04
`define SSAM_OFS_FUNC_TWO 8'h08
`define SSAM_OFS_OVF_LEVEL 8'h0c
`define SSAM_OFS_ALARM 8'h10
`define SSAM_OFS_DISPLAY 8'h14
`define SSAM_OFS_HIST_BASE 2'h1
// ==========================================================
// Reset values
`define SSAM_FUNC_TWO_RST 16'h0000
`define SSAM_OVF_LEVEL_RST 24'h000400
// ==========================================================
// First status word bit positions
`define SSAM_S1_ALARM 1
`define SSAM_S1_DBRAKE 2
`define SSAM_S1_REVERSE 3
`define SSAM_S1_ROTATE 4
`define SSAM_S1_REACHED 5
`define SSAM_S1_PCTRL 6
`define SSAM_S1_ENERGISED 9
`define SSAM_S1_ENC_A 10
`define SSAM_S1_ENC_B 11
`define SSAM_S1_ENC_Z 12
`define SSAM_S1_POLE_U 13
`define SSAM_S1_POLE_V 14
`define SSAM_S1_POLE_W 15
`define SSAM_S1_RUN 16
`define SSAM_S1_GAIN_RED 17
`define SSAM_S1_FWD_INH 18
`define SSAM_S1_REV_INH 19
// Second status word bit positions
`define SSAM_S2_CLOCKWISE 1
`define SSAM_S2_COUNTERCLOCK 2
`define SSAM_S2_DEV_CLR 3
// Reverse rotation select bit in function_select_two
`define SSAM_FS2_REVERSE 0
// ==========================================================
// Alarm codes as shown on the display
`define SSAM_CODE_NONE 8'h00
`define SSAM_CODE_A02 8'h02
`define SSAM_CODE_A31 8'h31
`define SSAM_CODE_A70 8'h70
`define SSAM_CODE_AC3 8'hc3
`define SSAM_CODE_AC4 8'hc4
`define SSAM_CODE_A99 8'h99
// Communication failure display codes
`define SSAM_CPF00 8'h00
`define SSAM_CPF01 8'h01
// ==========================================================
// Thresholds and sizes
`define SSAM_ROT_LEVEL 16'h0014
`define SSAM_OL_RATED_PCT 10'h078
`define SSAM_OL_TRIP 24'h100000
`define SSAM_OL_DECAY 24'h000004
`define SSAM_HIST_DEPTH 10
`define SSAM_MON_LAST 4'h9
`define SSAM_MON_STAT_ONE 4'h5
`define SSAM_MON_STAT_TWO 4'h6
`endif

// *** logic/ssam_overload.sv ***
// Inverse-time overload accumulator for the servo alarm monitor
`timescale 1ns/1ps
`include "ssam_defs.svh"
module ssam_overload #(
   parameter logic [23:0] TRIP_LEVEL = `SSAM_OL_TRIP
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [9:0] torque_pct,
   output logic trip
);
   // ==========================================================
   // Excess over rated load fills the bucket, so higher load trips sooner
   logic [23:0] acc;
   logic [23:0] next_acc;
   logic over;
   logic [23:0] excess;
   logic [24:0] sum;
   assign over = torque_pct > `SSAM_OL_RATED_PCT;
   assign excess = {14'h0000, torque_pct - `SSAM_OL_RATED_PCT};
   assign sum = {1'b0, acc} + {1'b0, excess};
   assign next_acc = over ? (sum[24] ? 24'hffffff : sum[23:0]) :
                     (acc > `SSAM_OL_DECAY) ? acc - `SSAM_OL_DECAY : 24'h000000;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         acc <= 24'h000000;
         trip <= 1'b0;
      end else begin
         acc <= next_acc;
         trip <= next_acc >= TRIP_LEVEL;
      end
   end
endmodule : ssam_overload

// *** logic/ssam_pkg.sv ***
// Types shared by the servo status and alarm monitor
package ssam_pkg;
   // Display modes, one-hot
   typedef enum logic [3:0] {
      SSAM_MODE_STATUS = 4'h1,
      SSAM_MODE_SETTINGS = 4'h2,
      SSAM_MODE_MONITOR = 4'h4,
      SSAM_MODE_HISTORY = 4'h8
   } ssam_mode_t;
   // What the display currently shows
   typedef enum logic [2:0] {
      SSAM_DK_IDLE = 3'h0,
      SSAM_DK_ALARM = 3'h1,
      SSAM_DK_CPF = 3'h2,
      SSAM_DK_MON_NO = 3'h3,
      SSAM_DK_MON_DATA = 3'h4,
      SSAM_DK_HIST = 3'h5
   } ssam_disp_kind_t;
   typedef struct packed {
      ssam_disp_kind_t kind;
      logic [20:0] value;
   } ssam_disp_t;
   typedef struct packed {
      logic mode_set;
      logic data;
      logic up;
      logic down;
   } ssam_keys_t;
   typedef struct packed {
      logic run_cmd;
      logic fwd_drive_inhibit;
      logic rev_drive_inhibit;
      logic clockwise_pulse_active;
      logic counterclock_pulse_active;
      logic dev_counter_clear_in;
      logic dyn_brake_active;
      logic p_control_active;
      logic gain_reduced;
      logic enc_a;
      logic enc_b;
      logic enc_z;
      logic pole_sensor_u;
      logic pole_sensor_v;
      logic pole_sensor_w;
   } ssam_drv_in_t;
   typedef struct packed {
      logic checksum_bad;
      logic enc_ab_fault;
      logic enc_s_fault;
      logic reset_powerup;
      logic panel_no_link;
      logic panel_timeout;
   } ssam_fault_in_t;
endpackage : ssam_pkg

// *** logic/ssam_top.sv ***
// Status words, alarm detection, alarm history and monitor display of the servo driver
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ssam_defs.svh"
// ==========================================================
module ssam_top import ssam_pkg::*; #(
   parameter int DEV_W = 24,
   parameter logic [23:0] OL_TRIP = `SSAM_OL_TRIP
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire ssam_keys_t keys,
   input wire ssam_drv_in_t drv,
   input wire ssam_fault_in_t flt,
   input wire logic [15:0] speed_rpm,
   input wire logic [15:0] speed_cmd,
   input wire logic [9:0] torque_pct,
   input wire logic [DEV_W-1:0] dev_count,
   output logic alarm_out_ok,
   output logic power_drive_en,
   output logic [7:0] alarm_code,
   output ssam_disp_t disp
);
   localparam int HD = `SSAM_HIST_DEPTH;
   // ==========================================================
   // AHB-Lite slave: zero wait, always OKAY
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [15:0] function_select_two;
   logic [DEV_W-1:0] ovf_level;
   logic [31:0] rd_mux;
   wire take = hsel & hready & htrans[1];
   wire wr_func = wr_pend & (wr_addr == `SSAM_OFS_FUNC_TWO);
   wire wr_ovf = wr_pend & (wr_addr == `SSAM_OFS_OVF_LEVEL);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         wr_pend <= take & hwrite;
         wr_addr <= {haddr[7:2], 2'h0};
         hrdata <= (take & ~hwrite) ? rd_mux : 32'h00000000;
      end
   end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         function_select_two <= `SSAM_FUNC_TWO_RST;
         ovf_level <= DEV_W'(`SSAM_OVF_LEVEL_RST);
      end else begin
         if (wr_func)
            function_select_two <= hwdata[15:0];
         if (wr_ovf)
            ovf_level <= hwdata[DEV_W-1:0];
      end
   end
   // ==========================================================
   // Status words
   logic [20:0] stat_one;
   logic [20:0] stat_two;
   logic [20:0] next_one;
   logic [20:0] next_two;
   logic alarm_flag;
   always_comb begin
      next_one = 21'h000000;
      next_one[`SSAM_S1_ALARM] = alarm_flag;
      next_one[`SSAM_S1_DBRAKE] = drv.dyn_brake_active;
      next_one[`SSAM_S1_REVERSE] = function_select_two[`SSAM_FS2_REVERSE];
      next_one[`SSAM_S1_ROTATE] = speed_rpm >= `SSAM_ROT_LEVEL;
      next_one[`SSAM_S1_REACHED] = speed_rpm >= speed_cmd;
      next_one[`SSAM_S1_PCTRL] = drv.p_control_active;
      next_one[`SSAM_S1_ENERGISED] = power_drive_en;
      next_one[`SSAM_S1_ENC_A] = drv.enc_a;
      next_one[`SSAM_S1_ENC_B] = drv.enc_b;
      next_one[`SSAM_S1_ENC_Z] = drv.enc_z;
      next_one[`SSAM_S1_POLE_U] = drv.pole_sensor_u;
      next_one[`SSAM_S1_POLE_V] = drv.pole_sensor_v;
      next_one[`SSAM_S1_POLE_W] = drv.pole_sensor_w;
      next_one[`SSAM_S1_RUN] = drv.run_cmd;
      next_one[`SSAM_S1_GAIN_RED] = drv.gain_reduced;
      next_one[`SSAM_S1_FWD_INH] = drv.fwd_drive_inhibit;
      next_one[`SSAM_S1_REV_INH] = drv.rev_drive_inhibit;
   end
   always_comb begin
      next_two = 21'h000000;
      next_two[`SSAM_S2_CLOCKWISE] = drv.clockwise_pulse_active;
      next_two[`SSAM_S2_COUNTERCLOCK] = drv.counterclock_pulse_active;
      next_two[`SSAM_S2_DEV_CLR] = drv.dev_counter_clear_in;
   end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stat_one <= 21'h000000;
         stat_two <= 21'h000000;
      end else begin
         stat_one <= next_one;
         stat_two <= next_two;
      end
   end
   // ==========================================================
   // Error detection, fixed priority when several arrive together
   logic ol_trip;
   ssam_overload #(
      .TRIP_LEVEL(OL_TRIP)
   ) u_overload (
      .clk(clk),
      .resetn(resetn),
      .torque_pct(torque_pct),
      .trip(ol_trip)
   );
   wire err_a02 = flt.checksum_bad;
   wire err_a31 = dev_count > ovf_level;
   wire err_a70 = ol_trip;
   wire err_ac3 = flt.enc_ab_fault;
   wire err_ac4 = flt.enc_s_fault;
   wire any_err = err_a02 | err_a31 | err_a70 | err_ac3 | err_ac4;
   wire raise = any_err & ~alarm_flag;
   wire [7:0] new_code = err_a02 ? `SSAM_CODE_A02 :
                         err_a31 ? `SSAM_CODE_A31 :
                         err_a70 ? `SSAM_CODE_A70 :
                         err_ac3 ? `SSAM_CODE_AC3 : `SSAM_CODE_AC4;
   logic [1:0] cpf_seen;
   // Alarm holds until reset; clearing lies outside this block
   always_ff @(posedge clk) begin
      if (!resetn) begin
         alarm_flag <= 1'b0;
         alarm_code <= `SSAM_CODE_NONE;
         power_drive_en <= 1'b0;
         cpf_seen <= 2'h0;
      end else begin
         if (raise) begin
            alarm_flag <= 1'b1;
            alarm_code <= new_code;
         end
         power_drive_en <= drv.run_cmd & ~alarm_flag & ~any_err;
         cpf_seen <= cpf_seen | {flt.panel_timeout, flt.panel_no_link};
      end
   end
   assign alarm_out_ok = ~alarm_flag;
   // ==========================================================
   // Alarm history, entry 0 most recent
   logic [7:0] hist [HD];
   logic [3:0] hist_count;
   wire log_en = raise | flt.reset_powerup;
   wire [7:0] log_code = raise ? new_code : `SSAM_CODE_A99;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hist_count <= 4'h0;
         for (int i = 0; i < HD; i++)
            hist[i] <= `SSAM_CODE_NONE;
      end else if (log_en) begin
         hist[0] <= log_code;
         for (int i = 1; i < HD; i++)
            hist[i] <= hist[i-1];
         if (hist_count != 4'(HD))
            hist_count <= hist_count + 4'h1;
      end
   end
   // ==========================================================
   // Display navigation
   ssam_mode_t mode;
   ssam_mode_t next_mode;
   logic show_data;
   logic [3:0] mon_no;
   logic [3:0] hist_idx;
   always_comb begin
      next_mode = mode;
      if (keys.mode_set) begin
         unique case (mode)
            SSAM_MODE_STATUS: next_mode = SSAM_MODE_SETTINGS;
            SSAM_MODE_SETTINGS: next_mode = SSAM_MODE_MONITOR;
            SSAM_MODE_MONITOR: next_mode = SSAM_MODE_HISTORY;
            SSAM_MODE_HISTORY: next_mode = SSAM_MODE_STATUS;
            default: next_mode = SSAM_MODE_STATUS;
         endcase
      end
   end
   wire in_mon = mode == SSAM_MODE_MONITOR;
   wire in_hist = mode == SSAM_MODE_HISTORY;
   wire step_up = keys.up & ~keys.down;
   wire step_dn = keys.down & ~keys.up;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode <= SSAM_MODE_STATUS;
         show_data <= 1'b0;
         mon_no <= 4'h0;
         hist_idx <= 4'h0;
      end else begin
         mode <= next_mode;
         if (keys.mode_set)
            show_data <= 1'b0;
         else if (in_mon & keys.data)
            show_data <= ~show_data;
         if (in_mon & ~show_data & step_up & (mon_no != `SSAM_MON_LAST))
            mon_no <= mon_no + 4'h1;
         else if (in_mon & ~show_data & step_dn & (mon_no != 4'h0))
            mon_no <= mon_no - 4'h1;
         if (in_hist & step_up & (hist_idx != 4'(HD - 1)))
            hist_idx <= hist_idx + 4'h1;
         else if (in_hist & step_dn & (hist_idx != 4'h0))
            hist_idx <= hist_idx - 4'h1;
      end
   end
   // ==========================================================
   // Display contents
   wire [20:0] mon_val = (mon_no == `SSAM_MON_STAT_ONE) ? stat_one :
                         (mon_no == `SSAM_MON_STAT_TWO) ? stat_two : 21'h000000;
   wire [7:0] cpf_code = cpf_seen[0] ? `SSAM_CPF00 : `SSAM_CPF01;
   ssam_disp_t next_disp;
   always_comb begin
      next_disp.kind = SSAM_DK_IDLE;
      next_disp.value = 21'h000000;
      if (in_mon) begin
         next_disp.kind = show_data ? SSAM_DK_MON_DATA : SSAM_DK_MON_NO;
         next_disp.value = show_data ? mon_val : {17'h00000, mon_no};
      end else if (in_hist) begin
         next_disp.kind = SSAM_DK_HIST;
         next_disp.value = {13'h0000, hist[hist_idx]};
      end else if (mode == SSAM_MODE_STATUS) begin
         if (alarm_flag) begin
            next_disp.kind = SSAM_DK_ALARM;
            next_disp.value = {13'h0000, alarm_code};
         end else if (cpf_seen != 2'h0) begin
            next_disp.kind = SSAM_DK_CPF;
            next_disp.value = {13'h0000, cpf_code};
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!resetn)
         disp <= '0;
      else
         disp <= next_disp;
   end
   // ==========================================================
   // Register read selection
   wire [7:0] ra = {haddr[7:2], 2'h0};
   wire hist_hit = (haddr[7:6] == `SSAM_OFS_HIST_BASE) & (haddr[5:2] < 4'(HD));
   wire [31:0] hist_rd = hist_hit ? {24'h000000, hist[haddr[5:2]]} : 32'h00000000;
   wire [31:0] alarm_rd = {14'h0000, cpf_seen, 2'h0, hist_count, 1'b0, alarm_flag, alarm_code};
   wire [31:0] disp_rd = {1'b0, disp.kind, 3'h0, show_data, mode, mon_no, hist_idx, 12'h000};
   assign rd_mux = (ra == `SSAM_OFS_STAT_ONE) ? {11'h000, stat_one} :
                   (ra == `SSAM_OFS_STAT_TWO) ? {11'h000, stat_two} :
                   (ra == `SSAM_OFS_FUNC_TWO) ? {16'h0000, function_select_two} :
                   (ra == `SSAM_OFS_OVF_LEVEL) ? 32'(ovf_level) :
                   (ra == `SSAM_OFS_ALARM) ? alarm_rd :
                   (ra == `SSAM_OFS_DISPLAY) ? disp_rd : hist_rd;
   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_DATA_TOGGLE: assert property (
      in_mon && keys.data && !keys.mode_set |=> show_data != $past(show_data))
      else $error("data key did not toggle monitor display");
   AST_MON_TO_HIST: assert property (
      in_mon && keys.mode_set |=> in_hist && !show_data)
      else $error("mode key in monitor did not reach history");
   AST_ALARM_BIT: assert property (
      raise |=> ##1 stat_one[`SSAM_S1_ALARM])
      else $error("alarm bit not shown two cycles after alarm");
   AST_REVERSE_BIT: assert property (
      stat_one[`SSAM_S1_REVERSE] == $past(function_select_two[`SSAM_FS2_REVERSE]))
      else $error("reverse bit does not follow function select");
   AST_ROTATE_BIT: assert property (
      ##1 stat_one[`SSAM_S1_ROTATE] == ($past(speed_rpm) >= 16'h0014))
      else $error("rotation bit wrong for speed");
   AST_PULSE_CLEAR_BITS: assert property (
      stat_two[`SSAM_S2_CLOCKWISE] == $past(drv.clockwise_pulse_active) &&
      stat_two[`SSAM_S2_DEV_CLR] == $past(drv.dev_counter_clear_in))
      else $error("pulse or clear bit not shown");
   AST_ERR_CUTS_DRIVE: assert property (
      raise |=> alarm_flag && !alarm_out_ok && !power_drive_en && alarm_code == $past(new_code))
      else $error("error did not raise alarm and cut drive");
   AST_A02: assert property (
      !alarm_flag && flt.checksum_bad |=> alarm_flag && alarm_code == 8'h02)
      else $error("checksum mismatch did not raise a.02");
   AST_A31: assert property (
      !alarm_flag && !flt.checksum_bad && dev_count > ovf_level |=> alarm_code == 8'h31)
      else $error("deviation overflow did not raise a.31");
   AST_A99_NO_ALARM: assert property (
      !alarm_flag && !any_err && flt.reset_powerup |=> !alarm_flag && hist[0] == 8'h99)
      else $error("a.99 acted as an alarm or was not logged");
   AST_CPF_NOT_LOGGED: assert property (
      (flt.panel_no_link || flt.panel_timeout) && !log_en |=> $stable(hist_count) && cpf_seen != 2'h0)
      else $error("link failure was logged or not shown");
   AST_UNUSED_ZERO: assert property (
      !stat_one[7] && !stat_one[8] && !stat_one[20] && stat_two[20:4] == 17'h00000)
      else $error("unused status bit lit");
   AST_ALARM_SHOWN: assert property (
      alarm_flag && mode == SSAM_MODE_STATUS |=> disp.kind == SSAM_DK_ALARM && disp.value[7:0] == $past(alarm_code))
      else $error("alarm code not shown in status mode");
   AST_ALARM_STICKY: assert property (
      alarm_flag |=> alarm_flag && !power_drive_en && $stable(alarm_code))
      else $error("alarm dropped or drive restarted");
   AST_ENERGISED_BIT: assert property (
      stat_one[`SSAM_S1_ENERGISED] == $past(power_drive_en))
      else $error("energised bit does not follow drive");
   AST_REACHED_BIT: assert property (
      stat_one[`SSAM_S1_REACHED] == ($past(speed_rpm) >= $past(speed_cmd)))
      else $error("speed reached bit wrong");
   AST_A70: assert property (
      !alarm_flag && !err_a02 && !err_a31 && err_a70 |=> alarm_code == 8'h70)
      else $error("overload did not raise a.70");
   AST_AC3: assert property (
      !alarm_flag && !err_a02 && !err_a31 && !err_a70 && err_ac3 |=> alarm_code == 8'hc3)
      else $error("encoder A/B fault did not raise a.c3");
   AST_AC4: assert property (
      !alarm_flag && !err_a02 && !err_a31 && !err_a70 && !err_ac3 && err_ac4 |=> alarm_code == 8'hc4)
      else $error("encoder S fault did not raise a.c4");
   AST_CPF_SHOWN: assert property (
      !alarm_flag && mode == SSAM_MODE_STATUS && cpf_seen != 2'h0 |=> disp.kind == SSAM_DK_CPF)
      else $error("link failure not shown");
endmodule : ssam_top

// *** tb/ssam_motor_model.sv ***
// Motor and encoder model on the far side of the status monitor
`timescale 1ns/1ps
module ssam_motor_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic spin,
   input wire logic [15:0] target_rpm,
   output logic enc_a,
   output logic enc_b,
   output logic enc_z,
   output logic [15:0] speed_rpm
);
   logic [1:0] step;
   // Phases advance only while the shaft turns, index mark once a cycle of four
   always_ff @(posedge clk) begin
      if (!resetn) begin
         step <= 2'h0;
      end else if (spin) begin
         step <= step + 2'h1;
      end
   end
   assign enc_a = step[1];
   assign enc_b = step[1] ^ step[0];
   assign enc_z = (step == 2'h3);
   assign speed_rpm = target_rpm;
endmodule : ssam_motor_model

// *** tb/ssam_top_tb.sv ***
// Self-checking bench of the servo status and alarm monitor
`timescale 1ns/1ps
`include "ssam_defs.svh"
module ssam_top_tb import ssam_pkg::*;;
   logic clk, resetn, hsel, hwrite, hreadyout, hresp, alarm_out_ok, power_drive_en, spin;
   logic enc_a, enc_b, enc_z;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] speed_rpm, speed_cmd, target_rpm;
   logic [9:0] torque_pct;
   logic [23:0] dev_count;
   logic [7:0] alarm_code;
   ssam_keys_t keys;
   ssam_drv_in_t drv_host, drv;
   ssam_fault_in_t flt;
   ssam_disp_t disp;
   int num_errors = 0;
   int compares = 0;
   // Word one positions of each drive input bit, 32 and up meaning word two
   localparam int BITPOS [15] = '{15, 14, 13, 12, 11, 10, 17, 6, 2, 35, 34, 33, 19, 18, 16};
   localparam logic [7:0] CODES [6] = '{`SSAM_CODE_A02, `SSAM_CODE_A31, `SSAM_CODE_A70,
      `SSAM_CODE_AC3, `SSAM_CODE_AC4, `SSAM_CODE_A02};
   always_comb begin
      drv = drv_host;
      drv.enc_a = enc_a;
      drv.enc_b = enc_b;
      drv.enc_z = enc_z;
   end
   ssam_top #(.DEV_W(24), .OL_TRIP(24'h000100)) i_ssam_top (.clk(clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .keys(keys), .drv(drv), .flt(flt),
      .speed_rpm(speed_rpm), .speed_cmd(speed_cmd), .torque_pct(torque_pct), .dev_count(dev_count),
      .alarm_out_ok(alarm_out_ok), .power_drive_en(power_drive_en), .alarm_code(alarm_code), .disp(disp));
   ssam_motor_model i_ssam_motor_model (.clk(clk), .resetn(resetn), .spin(spin), .target_rpm(target_rpm),
      .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .speed_rpm(speed_rpm));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ==========================================================
   // Tasks
   task automatic give_verdict();
      $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         give_verdict();
      end
   endtask : wait_ready
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(name, x, exp);
   endtask : rdc
   task automatic press(input ssam_keys_t k);
      keys <= k;
      @(posedge clk);
      keys <= '0;
      cycles(2);
   endtask : press
   task automatic do_reset(input int n);
      resetn <= 1'b0;
      cycles(n);
      resetn <= 1'b1;
      @(posedge clk);
   endtask : do_reset
   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] e1, e2, x;
      int n;
      resetn = 1'b0; hsel = 1'b1; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'h2; hwdata = '0;
      keys = '0; drv_host = '0; flt = '0; speed_cmd = 16'h0001; target_rpm = '0; torque_pct = '0;
      dev_count = '0; spin = 1'b0;
      do_reset(6);
      rdc("ovf_level", 32'hc, 32'h400);
      rdc("unmapped", 32'h30, 32'h0);
      check("hresp", hresp, 32'h0);
      wr(32'h0, 32'hffffffff);
      rdc("word_one_ro", 32'h0, 32'h0);
      wr(32'h8, 32'hffffffff);
      rdc("func_two", 32'h8, 32'hffff);
      rdc("reverse", 32'h0, 32'h8);
      wr(32'h8, 32'h0);
      $display("test registers done");
      for (int j = 0; j < 15; j++) begin
         if (j < 3 || j > 5) begin
            drv_host <= ssam_drv_in_t'(15'h0001 << j);
            cycles(3);
            e1 = (BITPOS[j] < 32) ? (32'h1 << BITPOS[j]) : 32'h0;
            e2 = (BITPOS[j] < 32) ? 32'h0 : (32'h1 << (BITPOS[j] - 32));
            if (j == 14) e1 = e1 | 32'h200;
            rdc("word_one", 32'h0, e1);
            rdc("word_two", 32'h4, e2);
         end
      end
      drv_host <= '0;
      spin <= 1'b1;
      cycles(3);
      spin <= 1'b0;
      cycles(3);
      rdc("encoder", 32'h0, 32'h00001400);
      spin <= 1'b1;
      @(posedge clk);
      spin <= 1'b0;
      target_rpm <= 16'd19;
      speed_cmd <= 16'd0;
      cycles(2);
      rdc("slow", 32'h0, 32'h20);
      target_rpm <= 16'd20;
      speed_cmd <= 16'd25;
      cycles(2);
      rdc("turning", 32'h0, 32'h10);
      target_rpm <= '0;
      speed_cmd <= 16'h0001;
      $display("test status words done");
      drv_host.gain_reduced <= 1'b1;
      press('{1'b1, 1'b0, 1'b0, 1'b0});
      press('{1'b1, 1'b0, 1'b0, 1'b0});
      repeat (11) press('{1'b0, 1'b0, 1'b1, 1'b0});
      repeat (4) press('{1'b0, 1'b0, 1'b0, 1'b1});
      rdc("monitor_no", 32'h14, 32'h30450000);
      press('{1'b0, 1'b1, 1'b0, 1'b0});
      check("data_kind", disp.kind, SSAM_DK_MON_DATA);
      check("data_value", disp.value, 32'h20000);
      press('{1'b0, 1'b1, 1'b0, 1'b0});
      check("number_kind", disp.kind, SSAM_DK_MON_NO);
      press('{1'b1, 1'b0, 1'b0, 1'b0});
      bus(1'b0, 32'h14, 32'h0, x);
      check("history_mode", x[23:20], 32'h8);
      drv_host <= '0;
      $display("test display keys done");
      do_reset(2);
      flt.reset_powerup <= 1'b1;
      @(posedge clk);
      flt.reset_powerup <= 1'b0;
      cycles(2);
      rdc("log_99", 32'h40, 32'h99);
      check("no_alarm", alarm_out_ok, 32'h1);
      flt.panel_timeout <= 1'b1;
      @(posedge clk);
      flt.panel_timeout <= 1'b0;
      cycles(2);
      rdc("cpf_unlogged", 32'h10, 32'h00020400);
      check("cpf_kind", disp.kind, SSAM_DK_CPF);
      check("cpf01_code", disp.value, 32'h00000001);
      flt.panel_no_link <= 1'b1;
      @(posedge clk);
      flt.panel_no_link <= 1'b0;
      cycles(2);
      check("cpf00_code", disp.value, 32'h00000000);
      rdc("cpf_both", 32'h10, 32'h00030400);
      $display("test logged codes done");
      for (int k = 0; k < 6; k++) begin
         do_reset(2);
         drv_host.run_cmd <= 1'b1;
         wr(32'hc, 32'h10);
         dev_count <= 24'h10;
         torque_pct <= 10'd120;
         cycles(20);
         check("drive_on", power_drive_en, 32'h1);
         check("near_miss", alarm_out_ok, 32'h1);
         case (k)
            0: flt.checksum_bad <= 1'b1;
            1: dev_count <= 24'h11;
            2: torque_pct <= 10'd200;
            3: flt.enc_ab_fault <= 1'b1;
            4: flt.enc_s_fault <= 1'b1;
            default: flt <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
         endcase
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (alarm_out_ok !== 1'b0 && n < 100);
         if (alarm_out_ok !== 1'b0) begin
            num_errors++;
            give_verdict();
         end
         cycles(3);
         check("alarm_code", alarm_code, CODES[k]);
         check("drive_off", power_drive_en, 32'h0);
         check("alarm_shown", disp.kind, SSAM_DK_ALARM);
         check("alarm_disp", disp.value, {24'h000000, CODES[k]});
         rdc("alarm_logged", 32'h40, CODES[k]);
         bus(1'b0, 32'h0, 32'h0, x);
         check("alarm_bit", x[1], 32'h1);
         flt <= '0;
         dev_count <= '0;
         torque_pct <= '0;
         drv_host <= '0;
      end
      $display("test alarms done");
      give_verdict();
   end
endmodule : ssam_top_tb
